// >>> hw/rss_pkg.sv
// package: register map, field positions, types and the operation list for radio service/status
// Operation
// R1: auto_recal_enable set lets temperature drift start a receiver recalibration
// R2: recal_trigger in Standby starts calibration; recal_in_progress high until done
// R3: thermal_drift_flag shows drift beyond limit since last calibration
// R4: thermal_drift_limit codes 0..3 select 5,10,15,20 degrees; default code 1
// R5: thermal_watch_disable clear monitors temperature except in Sleep and Standby
// R6: temperature register is read-only reading, minus one degree per step
// R7: battery register holds detector enable and three-bit threshold select, default 2
// R8: op_state_reached sets when requested mode is reached, clears on mode change
// R9: receive_prepared sets in receive after rssi, agc, afc; clears leaving receive
// R10: transmit_prepared sets in transmit after ramp-up; clears leaving transmit
// R11: synth_locked_flag follows pll lock in synth, receive or transmit modes
// R12: signal strength flag sets over limit in receive; clears leaving or write one
// R13: timeout flag sets on timeout; clears leaving receive or buffer emptied
// R14: lead_in_found sets on valid preamble; clears on write one
// R15: sync_word_hit sets on match; clears leaving receive, empty, or continuous write one
// R16: buffer_at_capacity means 66 bytes; buffer_drained means zero bytes
// R17: buffer_above_mark set only while count strictly exceeds buffer_mark
// R18: overflow sets outside Sleep; write one clears flags and empties buffer
// R19: frame_transmitted sets when packet sent in transmit; clears leaving transmit
// R20: frame_received sets after last byte and crc if required; clears on empty
// R21: checksum_passed sets on good crc in receive; clears on empty
// R22: supply_low_flag sets below threshold; only a software write one clears it
// R23: writing zero to clearable flags or writing read-only bits changes nothing
package rss_pkg;
  localparam logic [7:0] ADDR_CAL   = 8'h3b;
  localparam logic [7:0] ADDR_TEMP  = 8'h3c;
  localparam logic [7:0] ADDR_BAT   = 8'h3d;
  localparam logic [7:0] ADDR_FLG1  = 8'h3e;
  localparam logic [7:0] ADDR_FLG2  = 8'h3f;
  localparam logic [1:0] LIMIT_RST  = 2'h1;
  localparam logic [2:0] TRIM_RST   = 3'h2;
  localparam int         BUF_DEPTH  = 66;
  localparam int         CAL_CYCLES = 16;
  // mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STBY  = 3'h1;
  localparam logic [2:0] MODE_FSTX  = 3'h2;
  localparam logic [2:0] MODE_TX    = 3'h3;
  localparam logic [2:0] MODE_FSRX  = 3'h4;
  localparam logic [2:0] MODE_RX    = 3'h5;
  // flag1 bits
  localparam int F1_READY = 7;
  localparam int F1_RXRDY = 6;
  localparam int F1_TXRDY = 5;
  localparam int F1_LOCK  = 4;
  localparam int F1_RSSI  = 3;
  localparam int F1_TMO   = 2;
  localparam int F1_PRE   = 1;
  localparam int F1_SYNC  = 0;
  // flag2 bits
  localparam int F2_FULL  = 7;
  localparam int F2_EMPTY = 6;
  localparam int F2_LEVEL = 5;
  localparam int F2_OVR   = 4;
  localparam int F2_SENT  = 3;
  localparam int F2_PAYLD = 2;
  localparam int F2_CRC   = 1;
  localparam int F2_LOBAT = 0;
  // calibration and battery register bits
  localparam int C_AUTO  = 7;
  localparam int C_START = 6;
  localparam int C_RUN   = 5;
  localparam int C_DRIFT = 3;
  localparam int C_LIMH  = 2;
  localparam int C_LIML  = 1;
  localparam int C_WOFF  = 0;
  localparam int B_EN    = 3;

  typedef enum logic [1:0] {
    RSS_CAL_IDLE,
    RSS_CAL_RUN
  } rss_cal_t;

  // events reported by the modem, buffer and analog sides
  typedef struct packed {
    logic       mode_reached;
    logic       rx_chain_done;
    logic       pa_ramped;
    logic       pll_locked;
    logic       rssi_over;
    logic       timeout;
    logic       preamble;
    logic       sync_hit;
    logic       packet_done;
    logic       payload_done;
    logic       crc_ok;
    logic       crc_check_on;
    logic       overrun;
    logic       supply_below;
    logic       packet_mode;
  } rss_evt_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rss_bus_t;
endpackage

// >>> hw/rss_cal.sv
// calibration sequencer and thermal drift comparison
`timescale 1ns/10ps
module rss_cal #(
  parameter int CAL_LEN = rss_pkg::CAL_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic       auto_go,
  input  wire logic [7:0] temp_now,
  input  wire logic [1:0] limit,
  output logic            running,
  output logic            drift
);
  if (CAL_LEN < 1 || CAL_LEN > 255)
  begin : g_bad_len
    $error("rss_cal: CAL_LEN out of range");
  end

  typedef struct packed {
    rss_pkg::rss_cal_t st;
    logic [7:0]        cnt;
    logic [7:0]        ref_temp;
  } rss_cal_state_t;

  rss_cal_state_t s_r;
  rss_cal_state_t s_nxt;
  logic [7:0]     diff;
  logic [7:0]     lim_deg;

  always_comb
  begin
    s_nxt   = s_r;
    diff    = (temp_now >= s_r.ref_temp) ? temp_now - s_r.ref_temp : s_r.ref_temp - temp_now;
    lim_deg = 8'(({6'h0, limit} + 8'h1) * 8'h5); // see R4
    drift   = diff > lim_deg; // see R3
    running = (s_r.st == rss_pkg::RSS_CAL_RUN); // see R2
    case (s_r.st)
      rss_pkg::RSS_CAL_IDLE:
      begin
        if (start || auto_go) // see R1
        begin
          s_nxt.st  = rss_pkg::RSS_CAL_RUN;
          s_nxt.cnt = 8'(CAL_LEN - 1);
        end
      end
      rss_pkg::RSS_CAL_RUN:
      begin
        if (s_r.cnt == 8'h0)
        begin
          s_nxt.st       = rss_pkg::RSS_CAL_IDLE;
          s_nxt.ref_temp = temp_now;
        end
        else
          s_nxt.cnt = s_r.cnt - 8'h1;
      end
      default: s_nxt.st = rss_pkg::RSS_CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '{rss_pkg::RSS_CAL_IDLE, 8'h0, 8'h0};
    else if (ce)
      s_r <= s_nxt;
  end
endmodule

// >>> hw/rss_top.sv
// service and status register bank with flag logic
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module rss_top #(
  parameter int BUF_BYTES = rss_pkg::BUF_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire rss_pkg::rss_bus_t bus,
  output logic [7:0]             rdata,
  input  wire logic [2:0]        mode,
  input  wire logic [7:0]        thermal_sample,
  input  wire rss_pkg::rss_evt_t evt,
  input  wire logic [6:0]        buffer_count,
  input  wire logic [6:0]        buffer_mark,
  output logic                   buffer_flush,
  output logic                   auto_recal_enable,
  output logic                   thermal_watch_active,
  output logic                   supply_detector_enable,
  output logic [2:0]             supply_threshold_select,
  output logic                   recal_in_progress
);
  if (BUF_BYTES < 1 || BUF_BYTES > 127)
  begin : g_bad_depth
    $error("rss_top: BUF_BYTES out of range");
  end

  typedef struct packed {
    logic [7:0] rdata;
    logic       auto_on;
    logic [1:0] limit;
    logic       watch_off;
    logic [7:0] temp;
    logic       bat_on;
    logic [2:0] trim;
    logic [7:0] f1;
    logic [7:0] f2;
    logic       flush;
    logic [2:0] mode_q;
    logic       watch_on;
  } rss_state_t;

  rss_state_t s_r;
  rss_state_t s_nxt;
  logic       srst_n;
  logic       cal_start;
  logic       cal_run;
  logic       drift;
  logic       mode_chg;
  logic       in_rx;
  logic       in_tx;
  logic       watching;
  logic       empty;
  logic [7:0] w1c1;
  logic [7:0] w1c2;
  logic       wr_cal;
  logic [1:0] rst_sync_r;

  rss_cal u_cal (
    .clk      (clk),
    .rst_n    (srst_n),
    .ce       (ce),
    .start    (cal_start),
    .auto_go  (s_r.auto_on && drift && watching && !cal_run),
    .temp_now (s_r.temp),
    .limit    (s_r.limit),
    .running  (cal_run),
    .drift    (drift)
  );

  // synchronised reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign srst_n = rst_sync_r[1];

  always_comb
  begin
    s_nxt    = s_r;
    in_rx    = (mode == rss_pkg::MODE_RX);
    in_tx    = (mode == rss_pkg::MODE_TX);
    mode_chg = (mode != s_r.mode_q);
    watching = !s_r.watch_off && mode != rss_pkg::MODE_SLEEP
               && mode != rss_pkg::MODE_STBY; // see R5
    empty    = (buffer_count == 7'h0);
    wr_cal   = bus.wr && bus.addr == rss_pkg::ADDR_CAL;
    cal_start = wr_cal && bus.wdata[rss_pkg::C_START]
                && mode == rss_pkg::MODE_STBY; // see R2
    w1c1 = (bus.wr && bus.addr == rss_pkg::ADDR_FLG1) ? bus.wdata : 8'h0; // see R23
    w1c2 = (bus.wr && bus.addr == rss_pkg::ADDR_FLG2) ? bus.wdata : 8'h0; // see R23
    s_nxt.mode_q = mode;
    s_nxt.flush  = 1'b0;
    s_nxt.watch_on = watching; // see R5
    if (watching)
      s_nxt.temp = thermal_sample; // see R6
    if (wr_cal)
    begin
      s_nxt.auto_on   = bus.wdata[rss_pkg::C_AUTO]; // see R1
      s_nxt.limit     = bus.wdata[rss_pkg::C_LIMH:rss_pkg::C_LIML]; // see R4
      s_nxt.watch_off = bus.wdata[rss_pkg::C_WOFF]; // see R5
    end
    if (bus.wr && bus.addr == rss_pkg::ADDR_BAT)
    begin
      s_nxt.bat_on = bus.wdata[rss_pkg::B_EN]; // see R7
      s_nxt.trim   = bus.wdata[2:0]; // see R7
    end
    // live status
    s_nxt.f1[rss_pkg::F1_READY] = (s_r.f1[rss_pkg::F1_READY] && !mode_chg)
                                  || (evt.mode_reached && !mode_chg); // see R8
    s_nxt.f1[rss_pkg::F1_RXRDY] = in_rx && (s_r.f1[rss_pkg::F1_RXRDY]
                                  || evt.rx_chain_done); // see R9
    s_nxt.f1[rss_pkg::F1_TXRDY] = in_tx && (s_r.f1[rss_pkg::F1_TXRDY]
                                  || evt.pa_ramped); // see R10
    s_nxt.f1[rss_pkg::F1_LOCK]  = evt.pll_locked && mode >= rss_pkg::MODE_FSTX; // see R11
    // sticky flags, set wins over clear; full, empty and level follow buffer_count except when an overrun write one forces them
    s_nxt.f1[rss_pkg::F1_RSSI] = (in_rx && evt.rssi_over) || (in_rx
                                 && s_r.f1[rss_pkg::F1_RSSI] && !w1c1[rss_pkg::F1_RSSI]); // see R12
    s_nxt.f1[rss_pkg::F1_TMO]  = evt.timeout || (s_r.f1[rss_pkg::F1_TMO]
                                 && in_rx && !empty); // see R13
    s_nxt.f1[rss_pkg::F1_PRE]  = evt.preamble || (s_r.f1[rss_pkg::F1_PRE]
                                 && !w1c1[rss_pkg::F1_PRE]); // see R14
    s_nxt.f1[rss_pkg::F1_SYNC] = evt.sync_hit || (s_r.f1[rss_pkg::F1_SYNC] && in_rx
                                 && !empty && !(w1c1[rss_pkg::F1_SYNC]
                                 && !evt.packet_mode)); // see R15
    s_nxt.f2[rss_pkg::F2_FULL]  = (buffer_count == 7'(BUF_BYTES)); // see R16
    s_nxt.f2[rss_pkg::F2_EMPTY] = empty; // see R16
    s_nxt.f2[rss_pkg::F2_LEVEL] = buffer_count > buffer_mark; // see R17
    s_nxt.f2[rss_pkg::F2_OVR]   = (evt.overrun && mode != rss_pkg::MODE_SLEEP)
                                  || (s_r.f2[rss_pkg::F2_OVR] && !w1c2[rss_pkg::F2_OVR]); // see R18
    s_nxt.f2[rss_pkg::F2_SENT]  = in_tx && (evt.packet_done || s_r.f2[rss_pkg::F2_SENT]); // see R19
    s_nxt.f2[rss_pkg::F2_PAYLD] = (in_rx && evt.payload_done && (!evt.crc_check_on
                                  || evt.crc_ok)) || (s_r.f2[rss_pkg::F2_PAYLD] && !empty); // see R20
    s_nxt.f2[rss_pkg::F2_CRC]   = (in_rx && evt.payload_done && evt.crc_ok)
                                  || (s_r.f2[rss_pkg::F2_CRC] && !empty); // see R21
    s_nxt.f2[rss_pkg::F2_LOBAT] = (s_r.bat_on && evt.supply_below)
                                  || (s_r.f2[rss_pkg::F2_LOBAT] && !w1c2[rss_pkg::F2_LOBAT]); // see R22
    if (w1c2[rss_pkg::F2_OVR] && !(evt.overrun && mode != rss_pkg::MODE_SLEEP))
    begin
      s_nxt.flush = 1'b1; // see R18
      s_nxt.f1[rss_pkg::F1_TMO:rss_pkg::F1_SYNC] = {evt.timeout, evt.preamble, evt.sync_hit};
      s_nxt.f2[rss_pkg::F2_PAYLD] = in_rx && evt.payload_done
                                    && (!evt.crc_check_on || evt.crc_ok);
      s_nxt.f2[rss_pkg::F2_CRC]   = in_rx && evt.payload_done && evt.crc_ok;
      s_nxt.f2[rss_pkg::F2_FULL] = 1'b0;
      s_nxt.f2[rss_pkg::F2_LEVEL] = 1'b0;
      s_nxt.f2[rss_pkg::F2_EMPTY] = 1'b1;
    end
    // read data one cycle later
    s_nxt.rdata = 8'h0;
    if (bus.rd)
    begin
      case (bus.addr)
        rss_pkg::ADDR_CAL:  s_nxt.rdata = {s_r.auto_on, 1'b0, cal_run, 1'b0, drift,
                                           s_r.limit, s_r.watch_off}; // see R2
        rss_pkg::ADDR_TEMP: s_nxt.rdata = s_r.temp; // see R6
        rss_pkg::ADDR_BAT:  s_nxt.rdata = {4'h0, s_r.bat_on, s_r.trim};
        rss_pkg::ADDR_FLG1: s_nxt.rdata = s_r.f1;
        rss_pkg::ADDR_FLG2: s_nxt.rdata = s_r.f2;
        default:            s_nxt.rdata = 8'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      s_r.rdata     <= 8'h0;
      s_r.auto_on   <= 1'b0;
      s_r.limit     <= rss_pkg::LIMIT_RST;
      s_r.watch_off <= 1'b0;
      s_r.temp      <= 8'h0;
      s_r.bat_on    <= 1'b0;
      s_r.trim      <= rss_pkg::TRIM_RST;
      s_r.f1        <= 8'h0;
      s_r.f2        <= 8'h40;
      s_r.flush     <= 1'b0;
      s_r.mode_q    <= rss_pkg::MODE_SLEEP;
      s_r.watch_on  <= 1'b0;
    end
    else if (ce)
    begin
      s_r.rdata     <= s_nxt.rdata;
      s_r.auto_on   <= s_nxt.auto_on;
      s_r.limit     <= s_nxt.limit;
      s_r.watch_off <= s_nxt.watch_off;
      s_r.temp      <= s_nxt.temp;
      s_r.bat_on    <= s_nxt.bat_on;
      s_r.trim      <= s_nxt.trim;
      s_r.f1        <= s_nxt.f1;
      s_r.f2        <= s_nxt.f2;
      s_r.flush     <= s_nxt.flush;
      s_r.mode_q    <= s_nxt.mode_q;
      s_r.watch_on  <= s_nxt.watch_on;
    end
  end

  assign rdata                   = s_r.rdata;
  assign buffer_flush            = s_r.flush;
  assign auto_recal_enable       = s_r.auto_on;
  assign thermal_watch_active    = s_r.watch_on;
  assign supply_detector_enable  = s_r.bat_on;
  assign supply_threshold_select = s_r.trim;
  assign recal_in_progress       = cal_run;
endmodule

// >>> verif/rss_properties.sv
// checker: timing and flag relations at the register bank ports
`timescale 1ns/10ps
module rss_properties #(
  parameter int BUF_BYTES = 66
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              ce,
  input wire rss_pkg::rss_bus_t bus,
  input wire logic [7:0]        rdata,
  input wire logic [2:0]        mode,
  input wire logic [7:0]        thermal_sample,
  input wire rss_pkg::rss_evt_t evt,
  input wire logic [6:0]        buffer_count,
  input wire logic [6:0]        buffer_mark,
  input wire logic              buffer_flush,
  input wire logic              auto_recal_enable,
  input wire logic              thermal_watch_active,
  input wire logic              supply_detector_enable,
  input wire logic [2:0]        supply_threshold_select,
  input wire logic              recal_in_progress
);
  logic [5:0] run_n;
  logic       wcal, wbat, wovr, rflg2, rmap, quiet, start;
  assign wcal = ce && bus.wr && bus.addr == 8'h3b;
  assign wbat = ce && bus.wr && bus.addr == 8'h3d;
  assign wovr = ce && bus.wr && bus.addr == 8'h3f && bus.wdata[4];
  assign rflg2 = ce && bus.rd && bus.addr == 8'h3f;
  assign rmap = ce && bus.rd && bus.addr >= 8'h3b && bus.addr <= 8'h3f;
  assign quiet = mode == 3'h0 || mode == 3'h1;
  assign start = wcal && bus.wdata[6] && !recal_in_progress;
  // cycles spent calibrating
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      run_n <= 6'h0;
    else
      run_n <= recal_in_progress ? run_n + 6'h1 : 6'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cal_start: assert property (start && mode == 3'h1 |=> recal_in_progress)
    else $error("calibration did not start");
  a_cal_refuse: assert property (start && mode != 3'h1 && !auto_recal_enable
    |=> !recal_in_progress) else $error("calibration started outside standby");
  a_cal_length: assert property ($fell(recal_in_progress) && run_n != 6'h0
    |-> run_n == rss_pkg::CAL_CYCLES) else $error("calibration length wrong");
  a_auto_write: assert property (wcal |=> auto_recal_enable == $past(bus.wdata[7]))
    else $error("auto enable not written");
  a_bat_write: assert property (wbat |=> {supply_detector_enable, supply_threshold_select}
    == $past(bus.wdata[3:0])) else $error("battery control not written");
  a_watch_quiet: assert property (quiet && $past(quiet) && $past(quiet, 2)
    |-> !thermal_watch_active) else $error("monitor active while quiet");
  a_flush_cause: assert property (buffer_flush |-> $past(wovr)
    ##1 (!buffer_flush || $past(wovr))) else $error("flush without write one");
  a_rd_quiet: assert property (!$past(rmap) && $past(ce) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_buf_flags: assert property (rflg2 && $stable(buffer_count) && $stable(buffer_mark)
    && !buffer_flush && !$past(buffer_flush) |=> rdata[7:5] == {$past(buffer_count) == BUF_BYTES,
    $past(buffer_count) == 7'h00, $past(buffer_count) > $past(buffer_mark)})
    else $error("buffer flags wrong");
  c_cal: cover property (start && mode == 3'h1 ##1 recal_in_progress);
  c_flush: cover property (buffer_flush);
  c_full: cover property (rflg2 && buffer_count == BUF_BYTES);
endmodule
bind rss_top rss_properties #(.BUF_BYTES(BUF_BYTES)) u_props (.clk(clk), .rst_n(rst_n), .ce(ce),
  .bus(bus), .rdata(rdata), .mode(mode), .thermal_sample(thermal_sample), .evt(evt),
  .buffer_count(buffer_count), .buffer_mark(buffer_mark), .buffer_flush(buffer_flush),
  .auto_recal_enable(auto_recal_enable), .thermal_watch_active(thermal_watch_active),
  .supply_detector_enable(supply_detector_enable),
  .supply_threshold_select(supply_threshold_select), .recal_in_progress(recal_in_progress));

// >>> verif/rss_top_tb.sv
// self-checking bench: register access, calibration and flags
`timescale 1ns/10ps
module rss_top_tb;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce = 1'b1;
  rss_pkg::rss_bus_t bus = '0;
  rss_pkg::rss_evt_t evt = '0;
  rss_pkg::rss_evt_t em [5];
  logic [7:0]        rdata, d;
  logic [7:0]        tsamp = 8'h00;
  logic [2:0]        mode = 3'h1;
  logic [2:0]        trim;
  logic [6:0]        cnt = 7'h00;
  logic              flush, auto_en, watch, det_en, busy;
  int                errors = 0;
  int                n_checks = 0;
  int                nflush = 0;
  int                i, j;
  logic [7:0]        rv [6] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h40, 8'h00};
  logic [7:0]        fa [5] = '{8'h3e, 8'h3e, 8'h3e, 8'h3f, 8'h3f};
  logic [7:0]        fb [5] = '{8'h08, 8'h02, 8'h01, 8'h01, 8'h10};
  logic [6:0]        bc [4] = '{7'h00, 7'h05, 7'h06, 7'h42};
  logic [7:0]        be [4] = '{8'h40, 8'h00, 8'h20, 8'ha0};
  rss_pkg::rss_evt_t xe [7];
  logic [2:0]        xm [7] = '{3'h2, 3'h5, 3'h3, 3'h3, 3'h5, 3'h3, 3'h5};
  logic [7:0]        xa [7] = '{8'h3e, 8'h3e, 8'h3e, 8'h3e, 8'h3e, 8'h3f, 8'h3f};
  logic [7:0]        xb [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h08, 8'h06};
  always #2 clk = ~clk;
  always @(posedge clk)
    if (flush === 1'b1)
      nflush <= nflush + 1;
  rss_top #(.BUF_BYTES(66)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus), .rdata(rdata),
    .mode(mode), .thermal_sample(tsamp), .evt(evt), .buffer_count(cnt), .buffer_mark(7'h05),
    .buffer_flush(flush), .auto_recal_enable(auto_en), .thermal_watch_active(watch),
    .supply_detector_enable(det_en), .supply_threshold_select(trim), .recal_in_progress(busy));
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic pulse(input rss_pkg::rss_evt_t m);
    @(posedge clk);
    evt <= evt | m;
    @(posedge clk);
    evt <= evt & ~m;
  endtask
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; k < 40 && busy !== v; k++)
      @(posedge clk);
    if (busy !== v)
    begin
      errors++;
      summarize();
    end
  endtask
  initial
  begin
    em[0] = '{rssi_over: 1'b1, default: 1'b0};
    em[1] = '{preamble: 1'b1, default: 1'b0};
    em[2] = '{sync_hit: 1'b1, default: 1'b0};
    em[3] = '{supply_below: 1'b1, default: 1'b0};
    em[4] = '{overrun: 1'b1, default: 1'b0};
    xe[0] = '{mode_reached: 1'b1, default: 1'b0};
    xe[1] = '{rx_chain_done: 1'b1, default: 1'b0};
    xe[2] = '{pa_ramped: 1'b1, default: 1'b0};
    xe[3] = '{pll_locked: 1'b1, default: 1'b0};
    xe[4] = '{timeout: 1'b1, default: 1'b0};
    xe[5] = '{packet_done: 1'b1, default: 1'b0};
    xe[6] = '{payload_done: 1'b1, crc_ok: 1'b1, crc_check_on: 1'b1, default: 1'b0};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      rd(8'h3b + 8'(i));
      chk("reset", d, rv[i]);
    end
    wr(8'h3d, 8'hfd);
    rd(8'h3d);
    chk("battery", d, 8'h0d);
    chk("battery out", {det_en, 4'h0, trim}, 8'h85);
    ce <= 1'b0;
    wr(8'h3d, 8'h00);
    ce <= 1'b1;
    rd(8'h3d);
    chk("frozen", d, 8'h0d);
    wr(8'h3b, 8'h81);
    mode <= 3'h5;
    rd(8'h3b);
    chk("cal", d, 8'h81);
    chk("auto watch", {auto_en, 6'h0, watch}, 8'h80);
    wr(8'h3b, 8'h00);
    tsamp <= 8'h20;
    repeat (3) @(posedge clk);
    rd(8'h3b);
    chk("drift", d, 8'h08);
    chk("watch", {7'h0, watch}, 8'h01);
    rd(8'h3c);
    chk("temp", d, 8'h20);
    mode <= 3'h1;
    wr(8'h3b, 8'h40);
    wait_busy(1'b1);
    rd(8'h3b);
    chk("running", d & 8'h20, 8'h20);
    wait_busy(1'b0);
    mode <= 3'h5;
    wr(8'h3b, 8'h40);
    repeat (3) @(posedge clk);
    chk("refused", {7'h0, busy}, 8'h00);
    for (i = 0; i < 4; i++)
      for (j = 0; j < 2; j++)
      begin
        wr(8'h3b, {5'h0, i[1:0], 1'b0});
        tsamp <= 8'h20 + 8'(5 * i + 5 + j);
        repeat (3) @(posedge clk);
        rd(8'h3b);
        chk("limit", d, {4'h0, j[0], i[1:0], 1'b0});
      end
    wr(8'h3b, 8'h86);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(8'h3b);
    chk("auto", d, 8'h86);
    cnt <= 7'h01;
    for (i = 0; i < 5; i++)
    begin
      pulse(em[i]);
      for (j = 0; j < 3; j++)
      begin
        if (j > 0)
          wr(fa[i], j == 1 ? 8'h00 : fb[i]);
        rd(fa[i]);
        chk("flag", d & fb[i], j == 2 ? 8'h00 : fb[i]);
      end
    end
    chk("flush", 8'(nflush), 8'h01);
    pulse(em[0]);
    mode <= 3'h1;
    repeat (2) @(posedge clk);
    rd(8'h3e);
    chk("rssi left", d & 8'h08, 8'h00);
    for (i = 0; i < 7; i++)
    begin
      mode <= xm[i];
      evt  <= xe[i];
      cnt  <= 7'h01;
      repeat (2) @(posedge clk);
      rd(xa[i]);
      chk("event", d & xb[i], xb[i]);
      mode <= 3'h1;
      evt  <= '0;
      cnt  <= 7'h00;
      repeat (2) @(posedge clk);
      rd(xa[i]);
      chk("event gone", d & xb[i], 8'h00);
    end
    for (i = 0; i < 4; i++)
    begin
      cnt <= bc[i];
      repeat (2) @(posedge clk);
      rd(8'h3f);
      chk("buffer", d & 8'he0, be[i]);
    end
    summarize();
  end
endmodule
